// file: logic/pmc_pkg.sv
package pmc_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] PMC_MODE_OFS   = 8'h00;
  localparam logic [7:0] PMC_EN_OFS     = 8'h04;
  localparam logic [7:0] PMC_CMD_OFS    = 8'h08;
  localparam logic [7:0] PMC_CFG_OFS    = 8'h0c;
  localparam logic [7:0] PMC_STAT_OFS   = 8'h10;
  localparam logic [7:0] PMC_THR_OFS    = 8'h14;
  localparam logic [7:0] PMC_ACDIS_OFS  = 8'h18;
  // ==========================================================
  // field positions
  localparam int PMC_EN_DET_POS   = 0;   // detect enable bits 3:0
  localparam int PMC_EN_CLS_POS   = 4;   // class enable bits 7:4
  localparam int PMC_EN_DIS_POS   = 8;   // disconnect enable bits 11:8
  localparam int PMC_CMD_DET_POS  = 0;
  localparam int PMC_CMD_CLS_POS  = 4;
  localparam int PMC_CMD_ON_POS   = 8;
  localparam int PMC_CMD_OFF_POS  = 12;
  localparam int PMC_CMD_RST_POS  = 16;  // per-port reset pushbutton
  localparam int PMC_CMD_ALL_POS  = 31;  // global reset-all
  localparam int PMC_CFG_RS_POS   = 0;   // per-port sense setting, 1 = 0.25 ohm
  localparam int PMC_CFG_HP_POS   = 4;   // per-port high power enable
  // ==========================================================
  // modes
  localparam logic [1:0] PMC_MODE_SHDN = 2'h0;
  localparam logic [1:0] PMC_MODE_MAN  = 2'h1;
  localparam logic [1:0] PMC_MODE_SEMI = 2'h2;
  localparam logic [1:0] PMC_MODE_AUTO = 2'h3;
  localparam logic [7:0] PMC_MODE_RST_AUTO = 8'hff;
  localparam logic [7:0] PMC_MODE_RST_HOST = 8'h00;
  // detect result codes
  localparam logic [2:0] PMC_DET_GOOD = 3'h4;
  // ==========================================================
  // thresholds in mA, class indexed
  localparam logic [9:0] PMC_CUT_C1 = 10'd112;
  localparam logic [9:0] PMC_CUT_C2 = 10'd206;
  localparam logic [9:0] PMC_CUT_C3 = 10'd375;
  localparam logic [9:0] PMC_CUT_C4 = 10'd638;
  localparam logic [9:0] PMC_LIM_LO = 10'd425;
  localparam logic [9:0] PMC_LIM_HI = 10'd850;
  // ==========================================================
  // timing
  localparam int PMC_CLK_MHZ      = 250;
  localparam int PMC_BACKOFF_MS   = 100;
  localparam int PMC_MID_MS       = 2000;
  localparam int PMC_BACKOFF_CYC  = PMC_BACKOFF_MS * 1000 * PMC_CLK_MHZ;
  localparam int PMC_MID_CYC      = PMC_MID_MS * 1000 * PMC_CLK_MHZ;
  localparam int PMC_GLITCH_US    = 1;
  localparam int PMC_GLITCH_CYC   = PMC_GLITCH_US * PMC_CLK_MHZ;
endpackage : pmc_pkg

// file: logic/pmc_top.sv
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
// Functional notes
// R1: four independent ports, each manual, semi-auto, standalone or shutdown.
// R2: mode 11 standalone if strap high else reserved; 10 semi, 01 manual, 00 off.
// R3: manual: one detect or class per command, power on or off on command.
// R4: host should use manual mode only for diagnostics and test.
// R5: semi-auto repeats detect and class, reports, powers only on command.
// R6: semi-auto detects only with detect enable; classifies only with class enable.
// R7: standalone like semi-auto but powers on after good detect, loads thresholds.
// R8: system keeps standalone strap high from reset onward.
// R9: shutdown mode: no detection and no power.
// R10: any mode: current-limit fault removes port power.
// R11: any mode: enabled disconnect event removes port power.
// R12: host power-off honoured any time in any mode.
// R13: full reset on power-up, reset pin low, or reset-all bit written.
// R14: straps latched only during reset.
// R15: strap high at reset configures all ports autonomous.
// R16: midspan strap selects midspan detection backoff timing.
// R17: standalone loads class-selected overload and limit pair.
// R18: threshold auto-load only when last reset had standalone strap high.
// R19: sense default 0.5 ohm strap low, 0.25 strap high; host may rewrite.
// R20: legacy ac-disconnect enables mirror dc-disconnect enables.
// R21: without classification the device assumes class 3 full power.
// R22: semi-auto waits 100 ms, or 2 s midspan, between detections.
// R23: semi-auto high power: power-on needs detect good, else start fault.
// R24: port shutdown pin low resets port like pushbutton; under 1 us filtered.
// R25: class 1,2,0/3,4 map to 112/425,206/425,375/425,638/850 mA.
module pmc_top #(
  parameter int BACKOFF_CYC = pmc_pkg::PMC_BACKOFF_CYC,
  parameter int MID_CYC     = pmc_pkg::PMC_MID_CYC
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // straps and shutdown pins
  input  wire logic        auto_strap_in,
  input  wire logic        mid_strap_in,
  input  wire logic [3:0]  port_shutdown_n_in,
  // analog front end per port
  output logic [3:0]       det_start_out,
  output logic [3:0]       cls_start_out,
  input  wire logic [3:0]  meas_done_in,
  input  wire logic [11:0] det_result_in,
  input  wire logic [11:0] cls_result_in,
  input  wire logic [3:0]  ilim_fault_in,
  input  wire logic [3:0]  disconnect_in,
  // power switches and thresholds
  output logic [3:0]       power_on_out,
  output logic [39:0]      icut_ma_out,
  output logic [39:0]      ilim_ma_out
);
  import pmc_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_DET = 5'b00010, ST_CLS = 5'b00100,
    ST_WAIT = 5'b01000, ST_ON = 5'b10000
  } pmc_state_t;

  // ==========================================================
  // strap capture and reset-all
  logic       auto_s1_reg, auto_s2_reg, auto_s3_reg;
  logic       mid_s1_reg, mid_s2_reg, mid_s3_reg;
  logic       auto_lat_reg, mid_lat_reg, cap_reg;
  logic       rst_all_reg;
  logic [1:0] fill_reg;
  wire        soft_rst = rst_all_reg;
  // capture only once the synchroniser holds real pin levels, not its reset zeros
  wire        cap_now  = !cap_reg && fill_reg == 2'h3 && auto_s2_reg == auto_s3_reg
                         && mid_s2_reg == mid_s3_reg;

  // strap synchroniser
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {auto_s1_reg, auto_s2_reg, auto_s3_reg} <= 3'h0;
      {mid_s1_reg, mid_s2_reg, mid_s3_reg}    <= 3'h0;
      fill_reg <= 2'h0;
    end else begin
      if (fill_reg != 2'h3) fill_reg <= fill_reg + 2'h1;
      {auto_s1_reg, auto_s2_reg, auto_s3_reg} <= {auto_strap_in, auto_s1_reg, auto_s2_reg};
      {mid_s1_reg, mid_s2_reg, mid_s3_reg}    <= {mid_strap_in, mid_s1_reg, mid_s2_reg};
    end
  end

  // straps latched once after each reset release
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cap_reg      <= 1'b0;
      auto_lat_reg <= 1'b0;
      mid_lat_reg  <= 1'b0;
    end else if (soft_rst) begin
      cap_reg <= 1'b0; // [R13]
    end else if (cap_now) begin
      cap_reg      <= 1'b1; // [R14]
      auto_lat_reg <= auto_s3_reg;
      mid_lat_reg  <= mid_s3_reg;
    end
  end

  // ==========================================================
  // apb decode
  wire        wr_en  = psel_in & penable_in & pwrite_in;
  wire        rd_en  = psel_in & penable_in & ~pwrite_in;
  wire        a_mode = paddr_in == PMC_MODE_OFS;
  wire        a_en   = paddr_in == PMC_EN_OFS;
  wire        a_cmd  = paddr_in == PMC_CMD_OFS;
  wire        a_cfg  = paddr_in == PMC_CFG_OFS;
  wire        a_stat = paddr_in == PMC_STAT_OFS;
  wire        a_thr  = paddr_in == PMC_THR_OFS;
  wire        a_ac   = paddr_in == PMC_ACDIS_OFS;
  wire        a_hit  = a_mode | a_en | a_cmd | a_cfg | a_stat | a_thr | a_ac;
  wire [31:0] cmd_w  = (wr_en && a_cmd && cap_reg) ? pwdata_in : 32'h0;

  logic [7:0]  mode_reg;
  logic [3:0]  det_en_reg, cls_en_reg, dis_en_reg, rs_reg, hp_reg;
  logic [3:0]  start_flt_reg;

  // software configuration, loaded from straps at capture
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_reg <= PMC_MODE_RST_HOST;
      {det_en_reg, cls_en_reg, dis_en_reg, rs_reg, hp_reg} <= 20'h0;
      rst_all_reg <= 1'b0;
    end else begin
      rst_all_reg <= cmd_w[PMC_CMD_ALL_POS]; // [R13]
      if (soft_rst) begin
        mode_reg <= PMC_MODE_RST_HOST;
        {det_en_reg, cls_en_reg, dis_en_reg, rs_reg, hp_reg} <= 20'h0;
      end else if (cap_now) begin
        mode_reg   <= auto_s3_reg ? PMC_MODE_RST_AUTO : PMC_MODE_RST_HOST; // [R15]
        det_en_reg <= {4{auto_s3_reg}};
        cls_en_reg <= {4{auto_s3_reg}};
        dis_en_reg <= {4{auto_s3_reg}};
        rs_reg     <= {4{auto_s3_reg}}; // [R19]
      end else if (wr_en) begin
        if (a_mode) mode_reg <= pwdata_in[7:0];
        if (a_en) begin
          det_en_reg <= pwdata_in[PMC_EN_DET_POS+:4];
          cls_en_reg <= pwdata_in[PMC_EN_CLS_POS+:4];
          dis_en_reg <= pwdata_in[PMC_EN_DIS_POS+:4];
        end
        if (a_ac) dis_en_reg <= pwdata_in[3:0]; // [R20]
        if (a_cfg) begin
          rs_reg <= pwdata_in[PMC_CFG_RS_POS+:4]; // [R19]
          hp_reg <= pwdata_in[PMC_CFG_HP_POS+:4];
        end
      end
    end
  end

  // ==========================================================
  // per-port shutdown pin filter and sequencers
  logic [2:0]  class_reg [4];
  logic [2:0]  det_reg   [4];
  logic [3:0]  on_reg;
  logic [3:0]  dstart_reg, cstart_reg;
  logic [39:0] icut_reg, ilim_reg;
  assign power_on_out  = on_reg;
  assign det_start_out = dstart_reg;
  assign cls_start_out = cstart_reg;
  assign icut_ma_out   = icut_reg;
  assign ilim_ma_out   = ilim_reg;

  // class to overload threshold
  function automatic logic [9:0] cut_of(input logic [2:0] c);
    case (c)
      3'h1:    cut_of = PMC_CUT_C1; // [R25]
      3'h2:    cut_of = PMC_CUT_C2;
      3'h4:    cut_of = PMC_CUT_C4;
      default: cut_of = PMC_CUT_C3; // [R21]
    endcase
  endfunction

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_port // [R1]
      logic        sh1_reg, sh2_reg, sh3_reg, pshut_reg;
      logic [8:0]  flt_cnt_reg;
      logic [31:0] wait_reg;
      pmc_state_t  st_reg;
      wire [1:0]   mval = mode_reg[2*p+:2];
      wire         is_auto = mval == PMC_MODE_AUTO && auto_lat_reg; // [R2]
      wire         is_semi = mval == PMC_MODE_SEMI;
      wire         is_man  = mval == PMC_MODE_MAN;
      wire         prst = pshut_reg | cmd_w[PMC_CMD_RST_POS+p] | soft_rst; // [R24]
      wire         off_req = cmd_w[PMC_CMD_OFF_POS+p] | ilim_fault_in[p]
                           | (disconnect_in[p] & dis_en_reg[p]);
      wire         on_cmd = cmd_w[PMC_CMD_ON_POS+p];
      wire         good = det_result_in[3*p+:3] == PMC_DET_GOOD;
      wire         on_ok = ~(is_semi & hp_reg[p]) | det_reg[p] == PMC_DET_GOOD;
      wire         can_on = on_cmd & (is_man | is_semi | is_auto) & ~off_req;
      wire [31:0]  backoff = mid_lat_reg ? MID_CYC : BACKOFF_CYC; // [R16] [R22]

      // shutdown pin filter, pulses under one microsecond ignored
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          {sh1_reg, sh2_reg, sh3_reg} <= 3'h7;
          flt_cnt_reg <= 9'h0;
          pshut_reg   <= 1'b0;
        end else begin
          {sh1_reg, sh2_reg, sh3_reg} <= {port_shutdown_n_in[p], sh1_reg, sh2_reg};
          if (sh2_reg | sh3_reg) flt_cnt_reg <= 9'h0;
          else if (flt_cnt_reg != 9'(PMC_GLITCH_CYC)) flt_cnt_reg <= flt_cnt_reg + 9'h1;
          pshut_reg <= ~sh2_reg & ~sh3_reg & flt_cnt_reg == 9'(PMC_GLITCH_CYC); // [R24]
        end
      end

      // port sequencer
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          st_reg <= ST_IDLE; on_reg[p] <= 1'b0; dstart_reg[p] <= 1'b0; cstart_reg[p] <= 1'b0;
          det_reg[p] <= 3'h0; class_reg[p] <= 3'h0; wait_reg <= 32'h0; start_flt_reg[p] <= 1'b0;
          icut_reg[10*p+:10] <= PMC_CUT_C3; ilim_reg[10*p+:10] <= PMC_LIM_LO;
        end else begin
          dstart_reg[p] <= 1'b0;
          cstart_reg[p] <= 1'b0;
          if (cmd_w[PMC_CMD_ON_POS+p] | cmd_w[PMC_CMD_DET_POS+p]) start_flt_reg[p] <= 1'b0;
          if (prst || mval == PMC_MODE_SHDN || (mval == PMC_MODE_AUTO && !auto_lat_reg)) begin
            st_reg <= ST_IDLE; on_reg[p] <= 1'b0; // [R9] [R2]
            if (prst) begin det_reg[p] <= 3'h0; class_reg[p] <= 3'h0; start_flt_reg[p] <= 1'b0; end
            if (soft_rst) begin
              icut_reg[10*p+:10] <= PMC_CUT_C3; // [R13]
              ilim_reg[10*p+:10] <= PMC_LIM_LO;
            end
          end else if (on_reg[p] && off_req) begin
            on_reg[p] <= 1'b0; st_reg <= ST_WAIT; wait_reg <= backoff; // [R10] [R11] [R12]
          end else if (can_on && !on_reg[p]) begin
            if (on_ok) begin on_reg[p] <= 1'b1; st_reg <= ST_ON; end // [R3] [R5]
            else start_flt_reg[p] <= 1'b1; // [R23]
          end else begin
            case (st_reg)
              ST_IDLE: begin
                if (is_man && cmd_w[PMC_CMD_DET_POS+p]) begin
                  dstart_reg[p] <= 1'b1; st_reg <= ST_DET; // [R3]
                end else if (is_man && cmd_w[PMC_CMD_CLS_POS+p]) begin
                  cstart_reg[p] <= 1'b1; st_reg <= ST_CLS;
                end else if ((is_semi || is_auto) && det_en_reg[p]) begin
                  dstart_reg[p] <= 1'b1; st_reg <= ST_DET; // [R6] [R5]
                end
              end
              ST_DET: if (meas_done_in[p]) begin
                det_reg[p] <= det_result_in[3*p+:3];
                if (is_man) st_reg <= ST_IDLE;
                else if (good && cls_en_reg[p]) begin
                  cstart_reg[p] <= 1'b1; st_reg <= ST_CLS; // [R6]
                end else if (good && is_auto && !off_req) begin
                  class_reg[p] <= 3'h0; st_reg <= ST_ON; on_reg[p] <= 1'b1; // [R21] [R7]
                  icut_reg[10*p+:10] <= PMC_CUT_C3; ilim_reg[10*p+:10] <= PMC_LIM_LO;
                end else begin
                  st_reg <= ST_WAIT; wait_reg <= backoff; // [R22]
                end
              end
              ST_CLS: if (meas_done_in[p]) begin
                class_reg[p] <= cls_result_in[3*p+:3];
                if (is_man) st_reg <= ST_IDLE;
                else if (is_auto && !off_req) begin
                  st_reg <= ST_ON; on_reg[p] <= 1'b1; // [R7] [R15]
                  icut_reg[10*p+:10] <= cut_of(cls_result_in[3*p+:3]); // [R17] [R18]
                  ilim_reg[10*p+:10] <= cls_result_in[3*p+:3] == 3'h4 ? PMC_LIM_HI : PMC_LIM_LO;
                end else begin
                  st_reg <= ST_WAIT; wait_reg <= backoff;
                end
              end
              ST_WAIT: begin
                if (wait_reg != 32'h0) wait_reg <= wait_reg - 32'h1;
                else st_reg <= ST_IDLE;
              end
              ST_ON: ;
              default: st_reg <= ST_IDLE;
            endcase
          end
        end
      end

      // assertions
      property p_shdn_off;
        @(posedge clk_in) disable iff (!nrst_in) (mval == PMC_MODE_SHDN) |=> !on_reg[p];
      endproperty
      a_shdn_off: assert property (p_shdn_off) else $error("power on in shutdown"); // [R9]
      property p_fault_off;
        @(posedge clk_in) disable iff (!nrst_in) (on_reg[p] && ilim_fault_in[p]) |=> !on_reg[p];
      endproperty
      a_fault_off: assert property (p_fault_off) else $error("fault left power on"); // [R10]
      property p_disc_off;
        @(posedge clk_in) disable iff (!nrst_in)
          (on_reg[p] && disconnect_in[p] && dis_en_reg[p]) |=> !on_reg[p];
      endproperty
      a_disc_off: assert property (p_disc_off) else $error("disconnect left power on"); // [R11]
      property p_cmd_off;
        @(posedge clk_in) disable iff (!nrst_in) cmd_w[PMC_CMD_OFF_POS+p] |=> !on_reg[p];
      endproperty
      a_cmd_off: assert property (p_cmd_off) else $error("off command ignored"); // [R12]
      property p_semi_no_self;
        @(posedge clk_in) disable iff (!nrst_in)
          (is_semi && !on_reg[p] && !on_cmd) |=> !on_reg[p];
      endproperty
      a_semi_no_self: assert property (p_semi_no_self) else $error("semi powered alone"); // [R5]
      property p_semi_det_en;
        @(posedge clk_in) disable iff (!nrst_in) (is_semi && !det_en_reg[p]) |-> !dstart_reg[p] || $past(st_reg) != ST_IDLE;
      endproperty
      a_semi_det_en: assert property (p_semi_det_en) else $error("detect without enable"); // [R6]
      property p_hp_flt;
        @(posedge clk_in) disable iff (!nrst_in)
          (can_on && !on_reg[p] && !on_ok && !prst && is_semi) |=> start_flt_reg[p] && !on_reg[p];
      endproperty
      a_hp_flt: assert property (p_hp_flt) else $error("start fault missing"); // [R23]
      property p_shpin;
        @(posedge clk_in) disable iff (!nrst_in) pshut_reg |=> !on_reg[p];
      endproperty
      a_shpin: assert property (p_shpin) else $error("shutdown pin ignored"); // [R24]
      c_on: cover property (@(posedge clk_in) disable iff (!nrst_in) is_auto && $rose(on_reg[p]));
      c_flt: cover property (@(posedge clk_in) disable iff (!nrst_in) $rose(start_flt_reg[p]));
      c_hi: cover property (@(posedge clk_in) disable iff (!nrst_in) ilim_reg[10*p+:10] == PMC_LIM_HI);
    end
  endgenerate

  // ==========================================================
  // read mux, zero wait state
  wire [31:0] stat_w = {8'h0, start_flt_reg, on_reg, class_reg[3], class_reg[2], class_reg[1],
                        class_reg[0], det_reg[3] == PMC_DET_GOOD, det_reg[2] == PMC_DET_GOOD,
                        det_reg[1] == PMC_DET_GOOD, det_reg[0] == PMC_DET_GOOD};
  wire [31:0] rd_w = a_mode ? {24'h0, mode_reg}
                   : a_en   ? {20'h0, dis_en_reg, cls_en_reg, det_en_reg}
                   : a_cfg  ? {22'h0, mid_lat_reg, auto_lat_reg, hp_reg, rs_reg} // hp at 4, rs at 0
                   : a_stat ? stat_w
                   : a_thr  ? {icut_reg[39:30], icut_reg[29:20], icut_reg[9:0], 2'h0}
                   : a_ac   ? {28'h0, dis_en_reg} : 32'h0;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) prdata_out <= 32'h0;
    else if (psel_in && !penable_in && !pwrite_in) prdata_out <= rd_w;
  end
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~a_hit;

  a_rdy: assert property (@(posedge clk_in) disable iff (!nrst_in) rd_en |-> pready_out)
    else $error("not ready");
  c_rd: cover property (@(posedge clk_in) disable iff (!nrst_in) rd_en && a_stat);
endmodule // pmc_top

// file: tb/pmc_afe_model.sv
`timescale 1ns/1ps
// ==========================================================
// analog front end stand-in: answers each measurement start
module pmc_afe_model #(
  parameter int DLY = 3
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // measurement requests and codes to report
  input  wire logic [3:0]  det_start_in,
  input  wire logic [3:0]  cls_start_in,
  input  wire logic [11:0] det_code_in,
  input  wire logic [11:0] cls_code_in,
  // answers
  output logic [3:0]       meas_done_out,
  output logic [11:0]      det_result_out,
  output logic [11:0]      cls_result_out
);
  int cnt [4];
  // per-port delay, done pulse after DLY cycles
  always_ff @(posedge clk_in or negedge nrst_in) begin
    for (int p = 0; p < 4; p++) begin
      if (!nrst_in) begin
        cnt[p] <= 0;
        meas_done_out[p] <= 1'b0;
      end else begin
        meas_done_out[p] <= (cnt[p] == 1);
        if (det_start_in[p] || cls_start_in[p]) cnt[p] <= DLY;
        else if (cnt[p] > 0) cnt[p] <= cnt[p] - 1;
      end
    end
  end
  // results only valid with done, inverted otherwise
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      det_result_out[3*p+:3] = meas_done_out[p] ? det_code_in[3*p+:3] : ~det_code_in[3*p+:3];
      cls_result_out[3*p+:3] = meas_done_out[p] ? cls_code_in[3*p+:3] : ~cls_code_in[3*p+:3];
    end
  end
endmodule // pmc_afe_model

// file: tb/pmc_top_tb.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the port mode controller
module pmc_top_tb;
  import pmc_pkg::*;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err;
  logic        auto_s = 1'b1;  // strap high from reset until t_reset_all drops it
  logic        mid_s = 1'b0;
  logic [3:0]  shdn_n = 4'hf, ilim_f = 4'h0, disc = 4'h0;
  logic [3:0]  det_st, cls_st, done, pwr;
  logic [11:0] det_res, cls_res;
  logic [11:0] det_code = 12'h924;  // all ports good
  logic [11:0] cls_code = 12'h421;  // classes 2,0,4,1
  logic [39:0] icut, ilim;
  int          bad_count = 0, checks = 0, cyc = 0, n;
  int          dc [4];
  always #2 clk_in = ~clk_in;
  pmc_top #(.BACKOFF_CYC(20), .MID_CYC(40)) pmc_top_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .auto_strap_in(auto_s), .mid_strap_in(mid_s), .port_shutdown_n_in(shdn_n), .det_start_out(det_st),
    .cls_start_out(cls_st), .meas_done_in(done), .det_result_in(det_res), .cls_result_in(cls_res),
    .ilim_fault_in(ilim_f), .disconnect_in(disc), .power_on_out(pwr), .icut_ma_out(icut), .ilim_ma_out(ilim));
  pmc_afe_model pmc_afe_model_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .det_start_in(det_st), .cls_start_in(cls_st),
    .det_code_in(det_code), .cls_code_in(cls_code), .meas_done_out(done), .det_result_out(det_res),
    .cls_result_out(cls_res));
  // ==========================================================
  // shared tasks
  task automatic final_report;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, whole run needs well under 5000 cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      $display("Error pready expected 1 seen %b", pready);
      bad_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_pwr(input int p, input logic v, input int lim);
    int k = 0;
    while (pwr[p] !== v && k < lim) begin
      @(posedge clk_in);
      k++;
    end
  endtask
  task automatic count_det(input int cycles);
    dc = '{0, 0, 0, 0};
    repeat (cycles) begin
      @(posedge clk_in);
      for (int p = 0; p < 4; p++) if (det_st[p] === 1'b1) dc[p]++;
    end
  endtask
  // one-cycle pulse on the fault or the disconnect lines
  task automatic pulse(input logic is_disc, input logic [3:0] v);
    @(posedge clk_in);
    if (is_disc) disc <= v;
    else ilim_f <= v;
    @(posedge clk_in);
    disc <= 4'h0;
    ilim_f <= 4'h0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_auto;
    chk("icut rst", {4{10'd375}}, icut);
    chk("ilim rst", {4{10'd425}}, ilim);
    apb(1'b0, PMC_MODE_OFS, 32'h0);
    chk("mode rst", 8'hff, rd[7:0]);
    apb(1'b0, PMC_CFG_OFS, 32'h0);
    chk("cfg rst", 32'h10f, rd & 32'h30f);
    apb(1'b1, PMC_EN_OFS, 32'hfff);
    n = 0;
    while (pwr !== 4'hf && n < 500) begin
      @(posedge clk_in);
      n++;
    end
    chk("auto power", 4'hf, pwr);
    chk("auto icut", {10'd206, 10'd375, 10'd638, 10'd112}, icut);
    chk("auto ilim", {10'd425, 10'd425, 10'd850, 10'd425}, ilim);
  endtask
  task automatic t_removal;
    pulse(1'b0, 4'h1);
    wait_pwr(0, 1'b0, 5);
    chk("fault off", 1'b0, pwr[0]);
    apb(1'b1, PMC_EN_OFS, 32'h0ff);
    pulse(1'b1, 4'h2);
    repeat (5) @(posedge clk_in);
    chk("disc ignored", 1'b1, pwr[1]);
    apb(1'b1, PMC_EN_OFS, 32'hfff);
    pulse(1'b1, 4'h2);
    wait_pwr(1, 1'b0, 5);
    chk("disc off", 1'b0, pwr[1]);
    apb(1'b1, PMC_CMD_OFS, 32'h4000);
    wait_pwr(2, 1'b0, 5);
    chk("host off", 1'b0, pwr[2]);
    apb(1'b1, PMC_ACDIS_OFS, 32'h0);
    apb(1'b0, PMC_EN_OFS, 32'h0);
    chk("mirror clr", 4'h0, rd[11:8]);
    apb(1'b1, PMC_ACDIS_OFS, 32'hffffffff);
    apb(1'b0, PMC_EN_OFS, 32'h0);
    chk("mirror set", 4'hf, rd[11:8]);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 33'h100000000, {err, rd});
  endtask
  task automatic t_reset_all;
    @(posedge clk_in);
    auto_s <= 1'b0;
    mid_s <= 1'b1;  // midspan strap for the next reset
    repeat (10) @(posedge clk_in);
    apb(1'b0, PMC_CFG_OFS, 32'h0);
    chk("strap held", 32'h100, rd & 32'h300);
    apb(1'b1, PMC_CMD_OFS, 32'h80000000);
    repeat (10) @(posedge clk_in);
    apb(1'b0, PMC_MODE_OFS, 32'h0);
    chk("mode host", 8'h00, rd[7:0]);
    apb(1'b0, PMC_CFG_OFS, 32'h0);
    chk("cfg host", 32'h200, rd & 32'h30f);
    chk("pwr cleared", 4'h0, pwr);
    chk("icut cleared", {4{10'd375}}, icut);
  endtask
  task automatic t_modes;
    apb(1'b1, PMC_MODE_OFS, 32'hc9);  // manual port used only as a test hook
    apb(1'b1, PMC_EN_OFS, 32'h0);
    apb(1'b1, PMC_CMD_OFS, 32'h00d);
    count_det(100);
    chk("manual once", 1, dc[0]);
    chk("semi no en", 0, dc[1]);
    chk("shutdown", 0, dc[2]);
    chk("reserved", 0, dc[3]);
    apb(1'b0, PMC_STAT_OFS, 32'h0);
    chk("stat good", 1'b1, rd[0]);
    apb(1'b1, PMC_CMD_OFS, 32'h10);
    repeat (20) @(posedge clk_in);
    chk("no autoload", 10'd375, icut[9:0]);
    apb(1'b1, PMC_CMD_OFS, 32'h500);
    repeat (3) @(posedge clk_in);
    chk("manual on", 4'h1, pwr);
    apb(1'b1, PMC_EN_OFS, 32'h002);  // host enables detect first
    count_det(200);
    chk("semi repeat", 1'b1, dc[1] >= 2 && dc[1] <= 5);
    chk("semi no pwr", 1'b0, pwr[1]);
    @(posedge clk_in);
    det_code <= 12'h904;
    apb(1'b1, PMC_CFG_OFS, 32'h20);
    apb(1'b0, PMC_CFG_OFS, 32'h0);
    chk("cfg rewrite", 32'h20, rd & 32'h3f);
    count_det(100);
    apb(1'b1, PMC_CMD_OFS, 32'h200);
    repeat (3) @(posedge clk_in);
    chk("hp refuse", 1'b0, pwr[1]);
    apb(1'b0, PMC_STAT_OFS, 32'h0);
    chk("start fault", 1'b1, rd[21]);
  endtask
  task automatic t_pin;
    @(posedge clk_in);
    shdn_n <= 4'he;
    repeat (100) @(posedge clk_in);
    shdn_n <= 4'hf;
    repeat (5) @(posedge clk_in);
    chk("glitch kept", 1'b1, pwr[0]);
    shdn_n <= 4'he;
    repeat (300) @(posedge clk_in);
    shdn_n <= 4'hf;
    wait_pwr(0, 1'b0, 10);
    chk("pin reset", 1'b0, pwr[0]);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    t_auto();
    t_removal();
    t_reset_all();
    t_modes();
    t_pin();
    final_report();
  end
endmodule // pmc_top_tb
